// >>> paof_regs.svh
`ifndef PAOF_REGS_SVH
`define PAOF_REGS_SVH

// Pin indices within port E
`define PAOF_PE_RX 0
`define PAOF_PE_TX 1
`define PAOF_PE_XCK 2
`define PAOF_PE_AIN1 3
`define PAOF_PE_SCL 4
`define PAOF_PE_SDA 5
`define PAOF_PE_DO 6
`define PAOF_PE_CLKO 7
// Pin indices within port F
`define PAOF_PF_TCK 4
`define PAOF_PF_TMS 5
`define PAOF_PF_TDO 6
`define PAOF_PF_TDI 7
// Port G pins
`define PAOF_PG_T1 3
`define PAOF_PG_T0 4
`define PAOF_PG_RST 5
// Port width
`define PAOF_W 8
// Clock edges after reset before the synchronised test clock is trusted
`define PAOF_SYNC_SETTLE 3'h5

`endif

// >>> paof_pkg.sv
`default_nettype none
package paof_pkg;
    // Test access controller states, one-hot
    typedef enum logic [15:0] {
        PAOF_TLR = 16'h0001,
        PAOF_RTI = 16'h0002,
        PAOF_SDS = 16'h0004,
        PAOF_CDR = 16'h0008,
        PAOF_SDR = 16'h0010,
        PAOF_E1D = 16'h0020,
        PAOF_PDR = 16'h0040,
        PAOF_E2D = 16'h0080,
        PAOF_UDR = 16'h0100,
        PAOF_SIS = 16'h0200,
        PAOF_CIR = 16'h0400,
        PAOF_SIR = 16'h0800,
        PAOF_E1I = 16'h1000,
        PAOF_PIR = 16'h2000,
        PAOF_E2I = 16'h4000,
        PAOF_UIR = 16'h8000
    } paof_tap_e;
    typedef logic [7:0] paof_byte_t;
endpackage
`default_nettype wire

// >>> paof_sync.sv
`include "paof_regs.svh"
`default_nettype none
// Three-stage pin synchroniser; output changes once stages two and three agree
module paof_sync
    import paof_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [`PAOF_W-1:0] d,
    output logic [`PAOF_W-1:0] q
);
    logic [`PAOF_W-1:0] s1;
    logic [`PAOF_W-1:0] s2;
    logic [`PAOF_W-1:0] s3;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1 <= 8'h00;
            s2 <= 8'h00;
            s3 <= 8'h00;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
        end
    end

    genvar i;
    generate
        for (i = 0; i < `PAOF_W; i++) begin : g_bit
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    q[i] <= 1'b0;
                end else if (s2[i] == s3[i]) begin
                    q[i] <= s3[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// >>> paof_tap.sv
`include "paof_regs.svh"
`default_nettype none
// Test access controller, advanced on sampled test-clock rising edges
module paof_tap
    import paof_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic enable,
    input wire logic tck_rise,
    input wire logic tms,
    output paof_tap_e state
);
    paof_tap_e next_state;

    always_comb begin
        next_state = state;
        case (state)
            PAOF_TLR: next_state = tms ? PAOF_TLR : PAOF_RTI;
            PAOF_RTI: next_state = tms ? PAOF_SDS : PAOF_RTI;
            PAOF_SDS: next_state = tms ? PAOF_SIS : PAOF_CDR;
            PAOF_CDR: next_state = tms ? PAOF_E1D : PAOF_SDR;
            PAOF_SDR: next_state = tms ? PAOF_E1D : PAOF_SDR;
            PAOF_E1D: next_state = tms ? PAOF_UDR : PAOF_PDR;
            PAOF_PDR: next_state = tms ? PAOF_E2D : PAOF_PDR;
            PAOF_E2D: next_state = tms ? PAOF_UDR : PAOF_SDR;
            PAOF_UDR: next_state = tms ? PAOF_SDS : PAOF_RTI;
            PAOF_SIS: next_state = tms ? PAOF_TLR : PAOF_CIR;
            PAOF_CIR: next_state = tms ? PAOF_E1I : PAOF_SIR;
            PAOF_SIR: next_state = tms ? PAOF_E1I : PAOF_SIR;
            PAOF_E1I: next_state = tms ? PAOF_UIR : PAOF_PIR;
            PAOF_PIR: next_state = tms ? PAOF_E2I : PAOF_PIR;
            PAOF_E2I: next_state = tms ? PAOF_UIR : PAOF_SIR;
            PAOF_UIR: next_state = tms ? PAOF_SDS : PAOF_RTI;
            default: next_state = PAOF_TLR;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= PAOF_TLR;
        end else if (!enable) begin
            state <= PAOF_TLR;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end
endmodule
`default_nettype wire

// >>> paof_port_override.sv
`include "paof_regs.svh"
`default_nettype none
module paof_port_override
    import paof_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic global_pullup_disable,
    input wire logic [7:0] pe_port,
    input wire logic [7:0] pe_ddr,
    input wire logic [7:0] pe_pin_change_enable,
    input wire logic pin_change_group0_enable,
    input wire logic receiver_enable_flag,
    input wire logic transmitter_enable_flag,
    input wire logic serial_transmit_line,
    input wire logic clock_output_fuse,
    input wire logic io_clock,
    input wire logic serif_two_wire_mode,
    input wire logic serif_three_wire_mode,
    input wire logic serial_clock_hold,
    input wire logic serial_clock_toggle_strobe,
    input wire logic serif_data_out,
    input wire logic start_condition_int_enable,
    input wire logic comparator_neg_digital_disable,
    input wire logic comparator_pos_digital_disable,
    input wire logic usart_sync_mode,
    input wire logic usart_ext_clock_out,
    input wire logic test_port_enable,
    input wire logic test_data_out,
    input wire logic [7:0] pf_port,
    input wire logic [7:0] pf_ddr,
    input wire logic [7:0] pg_pin_in,
    input wire logic [7:0] pe_pin_in,
    input wire logic [7:0] pf_pin_in,
    output logic [7:0] pe_out,
    output logic [7:0] pe_oe_n,
    output logic [7:0] pe_pullup,
    output logic [7:0] pe_in_enable,
    output logic [7:0] pe_toggle,
    output logic [7:0] pf_out,
    output logic [7:0] pf_oe_n,
    output logic [7:0] pf_pullup,
    output logic [7:0] pf_in_enable,
    output logic [3:0] converter_channel_en,
    output logic counter0_external_clock,
    output logic counter1_external_clock,
    output logic usart_external_clock,
    output logic reset_input_pin,
    output logic test_data_in,
    output logic test_mode_select,
    output paof_tap_e tap_state
);
    //==========================================================
    // Input synchronisers
    logic [7:0] pe_s;
    logic [7:0] pf_s;
    logic [7:0] pg_s;
    logic tck_prev;
    logic tck_rise;

    paof_sync u_sync_e (.clk(clk), .arst_n(arst_n), .d(pe_pin_in), .q(pe_s));
    paof_sync u_sync_f (.clk(clk), .arst_n(arst_n), .d(pf_pin_in), .q(pf_s));
    paof_sync u_sync_g (.clk(clk), .arst_n(arst_n), .d(pg_pin_in), .q(pg_s));

    //==========================================================
    // Override enables and values per port E pin
    logic [7:0] puoe, puov, ddoe, ddov, pvoe, pvov, dieoe, dieov;
    logic [7:0] pc;

    assign pc = pe_pin_change_enable & {8{pin_change_group0_enable}};

    always_comb begin
        puoe = 8'h00;
        puov = 8'h00;
        ddoe = 8'h00;
        ddov = 8'h00;
        pvoe = 8'h00;
        pvov = 8'h00;
        dieoe = pc;
        dieov = 8'hff;
        ddoe[`PAOF_PE_RX] = receiver_enable_flag;
        ddov[`PAOF_PE_RX] = 1'b0;
        puoe[`PAOF_PE_RX] = receiver_enable_flag;
        puov[`PAOF_PE_RX] = pe_port[`PAOF_PE_RX] & ~global_pullup_disable;
        puoe[`PAOF_PE_TX] = transmitter_enable_flag;
        ddoe[`PAOF_PE_TX] = transmitter_enable_flag;
        ddov[`PAOF_PE_TX] = 1'b1;
        pvoe[`PAOF_PE_TX] = transmitter_enable_flag;
        pvov[`PAOF_PE_TX] = serial_transmit_line;
        // external clock drive in sync mode with direction bit set
        pvoe[`PAOF_PE_XCK] = usart_sync_mode & pe_ddr[`PAOF_PE_XCK];
        pvov[`PAOF_PE_XCK] = usart_ext_clock_out;
        dieoe[`PAOF_PE_AIN1] = pc[`PAOF_PE_AIN1] | comparator_neg_digital_disable;
        dieov[`PAOF_PE_AIN1] = pc[`PAOF_PE_AIN1];
        dieoe[`PAOF_PE_XCK] = pc[`PAOF_PE_XCK] | comparator_pos_digital_disable;
        dieov[`PAOF_PE_XCK] = pc[`PAOF_PE_XCK];
        puoe[`PAOF_PE_SCL] = serif_two_wire_mode;
        ddoe[`PAOF_PE_SCL] = serif_two_wire_mode;
        ddov[`PAOF_PE_SCL] = (serial_clock_hold & pe_port[`PAOF_PE_SCL]) | pe_ddr[`PAOF_PE_SCL];
        pvoe[`PAOF_PE_SCL] = serif_two_wire_mode & pe_ddr[`PAOF_PE_SCL];
        puoe[`PAOF_PE_SDA] = serif_two_wire_mode;
        ddoe[`PAOF_PE_SDA] = serif_two_wire_mode;
        ddov[`PAOF_PE_SDA] = (pe_s[`PAOF_PE_SDA] | pe_port[`PAOF_PE_SDA]) & pe_ddr[`PAOF_PE_SDA];
        pvoe[`PAOF_PE_SDA] = serif_two_wire_mode & pe_ddr[`PAOF_PE_SDA];
        dieoe[`PAOF_PE_SCL] = pc[`PAOF_PE_SCL] | start_condition_int_enable;
        dieoe[`PAOF_PE_SDA] = pc[`PAOF_PE_SDA] | start_condition_int_enable;
        pvoe[`PAOF_PE_DO] = serif_three_wire_mode;
        pvov[`PAOF_PE_DO] = serif_data_out;
        ddoe[`PAOF_PE_CLKO] = clock_output_fuse;
        ddov[`PAOF_PE_CLKO] = 1'b1;
        pvoe[`PAOF_PE_CLKO] = clock_output_fuse;
        pvov[`PAOF_PE_CLKO] = io_clock;
    end

    //==========================================================
    // Port E pin drivers
    logic [7:0] pe_dir;
    logic [7:0] next_pe_out;
    logic [7:0] next_pe_pu;
    logic [7:0] next_pe_ie;

    assign pe_dir = (ddoe & ddov) | (~ddoe & pe_ddr);
    assign next_pe_out = (pvoe & pvov) | (~pvoe & pe_port);
    assign next_pe_pu = (puoe & puov) | (~puoe & pe_port & ~pe_dir & {8{~global_pullup_disable}});
    assign next_pe_ie = (dieoe & dieov) | ~dieoe;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pe_out <= 8'h00;
            pe_oe_n <= 8'hff;
            pe_pullup <= 8'h00;
            pe_in_enable <= 8'h00;
            pe_toggle <= 8'h00;
        end else begin
            pe_out <= next_pe_out;
            pe_oe_n <= ~pe_dir;
            pe_pullup <= next_pe_pu;
            pe_in_enable <= next_pe_ie;
            pe_toggle <= {3'h0, serif_two_wire_mode & serial_clock_toggle_strobe, 4'h0};
        end
    end

    //==========================================================
    // Test access controller
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tck_prev <= 1'b0;
        end else begin
            tck_prev <= pf_s[`PAOF_PF_TCK];
        end
    end

    // ignore the synchroniser's jump from its reset value to a pulled-up pin
    logic [2:0] tck_settle;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tck_settle <= 3'h0;
        end else if (tck_settle != `PAOF_SYNC_SETTLE) begin
            tck_settle <= tck_settle + 3'h1;
        end
    end

    // steps only on test clock rise
    assign tck_rise = pf_s[`PAOF_PF_TCK] & ~tck_prev & (tck_settle == `PAOF_SYNC_SETTLE);

    paof_tap u_tap (
        .clk(clk),
        .arst_n(arst_n),
        .enable(test_port_enable),
        .tck_rise(tck_rise),
        .tms(pf_s[`PAOF_PF_TMS]),
        .state(tap_state)
    );

    logic shifting;
    assign shifting = (tap_state == PAOF_SIR) || (tap_state == PAOF_SDR);

    //==========================================================
    // Port F pin drivers
    logic [7:0] pf_dir;
    logic [7:0] jt;
    assign jt = {4'hf, 4'h0} & {8{test_port_enable}};
    // data out drives only while shifting
    assign pf_dir = (~jt & pf_ddr) | ({1'b0, shifting, 6'h00} & jt);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pf_out <= 8'h00;
            pf_oe_n <= 8'hff;
            pf_in_enable <= 8'h00;
            test_data_in <= 1'b0;
            test_mode_select <= 1'b0;
            converter_channel_en <= 4'h0;
        end else begin
            pf_out <= (~jt & pf_port) | ({1'b0, test_data_out, 6'h00} & jt);
            pf_oe_n <= ~pf_dir;
            // input off on test pins except clock
            pf_in_enable <= (~jt & 8'hf0) | (jt & 8'h10);
            test_data_in <= pf_s[`PAOF_PF_TDI];
            test_mode_select <= pf_s[`PAOF_PF_TMS];
            converter_channel_en <= 4'hf;
        end
    end

    // pull-ups stay on under reset, so combinational from enable
    assign pf_pullup = jt | (~jt & pf_port & ~pf_ddr & {8{~global_pullup_disable}});

    //==========================================================
    // Port G inputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            counter0_external_clock <= 1'b0;
            counter1_external_clock <= 1'b0;
            reset_input_pin <= 1'b1;
            usart_external_clock <= 1'b0;
        end else begin
            counter0_external_clock <= pg_s[`PAOF_PG_T0];
            counter1_external_clock <= pg_s[`PAOF_PG_T1];
            reset_input_pin <= pg_s[`PAOF_PG_RST];
            // external clock input when direction clear
            usart_external_clock <= usart_sync_mode & ~pe_ddr[`PAOF_PE_XCK] & pe_s[`PAOF_PE_XCK];
        end
    end

    //==========================================================
    // Checks
    // receive pin input
    property p_rx_in;
        @(posedge clk) disable iff (!arst_n) receiver_enable_flag |=> pe_oe_n[0];
    endproperty
    a_rx_in: assert property (p_rx_in) else $error("rx pin driven");
    property p_rx_pu;
        @(posedge clk) disable iff (!arst_n)
            receiver_enable_flag |=> pe_pullup[0] == ($past(pe_port[0]) & ~$past(global_pullup_disable));
    endproperty
    a_rx_pu: assert property (p_rx_pu) else $error("rx pull-up wrong");
    property p_tx;
        @(posedge clk) disable iff (!arst_n)
            transmitter_enable_flag |=> !pe_oe_n[1] && !pe_pullup[1] && pe_out[1] == $past(serial_transmit_line);
    endproperty
    a_tx: assert property (p_tx) else $error("tx pin wrong");
    property p_clko;
        @(posedge clk) disable iff (!arst_n) clock_output_fuse |=> !pe_oe_n[7] && pe_out[7] == $past(io_clock);
    endproperty
    a_clko: assert property (p_clko) else $error("clock out wrong");
    property p_sda;
        @(posedge clk) disable iff (!arst_n) serif_two_wire_mode && pe_ddr[5] |=> !pe_out[5] && !pe_pullup[5];
    endproperty
    a_sda: assert property (p_sda) else $error("data pin not open drain");
    property p_do;
        @(posedge clk) disable iff (!arst_n) serif_three_wire_mode |=> pe_out[6] == $past(serif_data_out);
    endproperty
    a_do: assert property (p_do) else $error("data out wrong");
    property p_tdo;
        @(posedge clk) disable iff (!arst_n) test_port_enable && !shifting |=> pf_oe_n[6];
    endproperty
    a_tdo: assert property (p_tdo) else $error("tdo driven outside shift");
    property p_jpu;
        @(posedge clk) test_port_enable |-> pf_pullup[7:4] == 4'hf;
    endproperty
    a_jpu: assert property (p_jpu) else $error("test pull-ups off");
    property p_fie;
        @(posedge clk) disable iff (!arst_n) test_port_enable |=> pf_in_enable[7:4] == 4'h1 && pf_in_enable[3:0] == 4'h0;
    endproperty
    a_fie: assert property (p_fie) else $error("port F input enables wrong");
    property p_tap_hold;
        @(posedge clk) disable iff (!arst_n) test_port_enable && !tck_rise |=> $stable(tap_state);
    endproperty
    a_tap_hold: assert property (p_tap_hold) else $error("test controller moved without clock");
    property p_toggle;
        @(posedge clk) disable iff (!arst_n)
            serif_two_wire_mode && serial_clock_toggle_strobe |=> pe_toggle[4];
    endproperty
    a_toggle: assert property (p_toggle) else $error("clock pin toggle missing");
endmodule
`default_nettype wire

// >>> paof_pin_env.sv
`default_nettype none
// ==========================================
// Pin environment: resolves each port E and F pad level
module paof_pin_env (
    input wire logic clk,
    input wire logic [7:0] pe_out,
    input wire logic [7:0] pe_oe_n,
    input wire logic [7:0] pe_pullup,
    input wire logic [7:0] pf_out,
    input wire logic [7:0] pf_oe_n,
    input wire logic [7:0] pf_pullup,
    input wire logic [15:0] ext_en,
    input wire logic [15:0] ext_val,
    output logic [7:0] pe_pin_in,
    output logic [7:0] pf_pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] lvl;
    logic [15:0] last = 16'h0000;
    logic [15:0] drv;
    logic [15:0] oe_n;
    logic [15:0] pu;
    assign drv = {pf_out, pe_out};
    assign oe_n = {pf_oe_n, pe_oe_n};
    assign pu = {pf_pullup, pe_pullup};
    // driven pins hold steady
    // Own driver first, then far side, then pull-up; a floating pad keeps changing
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (!oe_n[i]) begin
                lvl[i] = drv[i];
            end else if (ext_en[i]) begin
                lvl[i] = ext_val[i];
            end else if (pu[i]) begin
                lvl[i] = 1'b1;
            end else begin
                lvl[i] = ~last[i];
            end
        end
    end
    always @(posedge clk) begin
        last <= lvl;
    end
    assign pe_pin_in = lvl[7:0];
    assign pf_pin_in = lvl[15:8];
endmodule
`default_nettype wire

// >>> port_alt_function_override_test.sv
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end
module port_alt_function_override_test
    import paof_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] port, ddr, pce;
        logic [13:0] ctl;
        logic [7:0] mask, oe, pull, out, ien;
    } paof_row_s;
    logic clk, arst_n, global_pullup_disable, pin_change_group0_enable, receiver_enable_flag;
    logic transmitter_enable_flag, serial_transmit_line, clock_output_fuse, io_clock, serif_two_wire_mode;
    logic serif_three_wire_mode, serial_clock_hold, serial_clock_toggle_strobe, serif_data_out;
    logic start_condition_int_enable, comparator_neg_digital_disable, comparator_pos_digital_disable;
    logic usart_sync_mode, usart_ext_clock_out, test_port_enable, test_data_out;
    logic [7:0] pe_port, pe_ddr, pe_pin_change_enable, pf_port, pf_ddr, pg_pin_in, pe_pin_in, pf_pin_in;
    logic [7:0] pe_out, pe_oe_n, pe_pullup, pe_in_enable, pe_toggle, pf_out, pf_oe_n, pf_pullup, pf_in_enable;
    logic [3:0] converter_channel_en;
    logic counter0_external_clock, counter1_external_clock, reset_input_pin, test_mode_select;
    logic usart_external_clock, test_data_in;
    logic [15:0] ext_val;
    paof_tap_e tap_state;
    int errors = 0;
    int comparisons = 0;
    paof_row_s rows [17];

    paof_port_override dut (.clk(clk), .arst_n(arst_n), .global_pullup_disable(global_pullup_disable),
        .pe_port(pe_port), .pe_ddr(pe_ddr), .pe_pin_change_enable(pe_pin_change_enable),
        .pin_change_group0_enable(pin_change_group0_enable), .receiver_enable_flag(receiver_enable_flag),
        .transmitter_enable_flag(transmitter_enable_flag), .serial_transmit_line(serial_transmit_line),
        .clock_output_fuse(clock_output_fuse), .io_clock(io_clock), .serif_two_wire_mode(serif_two_wire_mode),
        .serif_three_wire_mode(serif_three_wire_mode), .serial_clock_hold(serial_clock_hold),
        .serial_clock_toggle_strobe(serial_clock_toggle_strobe), .serif_data_out(serif_data_out),
        .start_condition_int_enable(start_condition_int_enable),
        .comparator_neg_digital_disable(comparator_neg_digital_disable),
        .comparator_pos_digital_disable(comparator_pos_digital_disable), .usart_sync_mode(usart_sync_mode),
        .usart_ext_clock_out(usart_ext_clock_out), .test_port_enable(test_port_enable),
        .test_data_out(test_data_out), .pf_port(pf_port), .pf_ddr(pf_ddr), .pg_pin_in(pg_pin_in),
        .pe_pin_in(pe_pin_in), .pf_pin_in(pf_pin_in), .pe_out(pe_out), .pe_oe_n(pe_oe_n),
        .pe_pullup(pe_pullup), .pe_in_enable(pe_in_enable), .pe_toggle(pe_toggle), .pf_out(pf_out),
        .pf_oe_n(pf_oe_n), .pf_pullup(pf_pullup), .pf_in_enable(pf_in_enable),
        .converter_channel_en(converter_channel_en), .counter0_external_clock(counter0_external_clock),
        .counter1_external_clock(counter1_external_clock), .usart_external_clock(usart_external_clock),
        .reset_input_pin(reset_input_pin), .test_data_in(test_data_in), .test_mode_select(test_mode_select),
        .tap_state(tap_state));

    paof_pin_env pins (.clk(clk), .pe_out(pe_out), .pe_oe_n(pe_oe_n), .pe_pullup(pe_pullup), .pf_out(pf_out),
        .pf_oe_n(pf_oe_n), .pf_pullup(pf_pullup), .ext_en(16'h3000), .ext_val(ext_val),
        .pe_pin_in(pe_pin_in), .pf_pin_in(pf_pin_in));

    // ==========================================
    // Clock, watchdog and verdict
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        repeat (4000) @(posedge clk);
        errors++;
        close_out();
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // One test-clock period with the given mode-select level
    task automatic tck(input logic tms);
        @(posedge clk);
        ext_val[13] <= tms;
        repeat (6) @(posedge clk);
        ext_val[12] <= 1'b1;
        repeat (6) @(posedge clk);
        ext_val[12] <= 1'b0;
        wait_cyc(6);
    endtask

    // ==========================================
    // Stimulus
    // ctl bits 0..13: rx tx txd fuse two three hold pud ioclk dout grp neg_dis sie pos_dis
    initial begin
        rows = '{'{8'ha5, 8'h3c, 8'h00, 14'h0000, 8'hff, 8'hc3, 8'h81, 8'ha5, 8'hff},
            '{8'h01, 8'h01, 8'h00, 14'h0001, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01},
            '{8'h01, 8'h01, 8'h00, 14'h0081, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01},
            '{8'h02, 8'h00, 8'h00, 14'h0006, 8'h02, 8'h00, 8'h00, 8'h02, 8'h02},
            '{8'h02, 8'h00, 8'h00, 14'h0002, 8'h02, 8'h00, 8'h00, 8'h00, 8'h02},
            '{8'h00, 8'h00, 8'h00, 14'h0108, 8'h80, 8'h00, 8'h00, 8'h80, 8'h80},
            '{8'h00, 8'h00, 8'h00, 14'h0008, 8'h80, 8'h00, 8'h00, 8'h00, 8'h80},
            '{8'h30, 8'h10, 8'h00, 14'h0010, 8'h30, 8'h20, 8'h00, 8'h20, 8'h30},
            '{8'h10, 8'h00, 8'h00, 14'h0050, 8'h10, 8'h00, 8'h00, 8'h10, 8'h10},
            '{8'h10, 8'h00, 8'h00, 14'h0010, 8'h10, 8'h10, 8'h00, 8'h10, 8'h10},
            '{8'h00, 8'h40, 8'h00, 14'h0220, 8'h40, 8'h00, 8'h00, 8'h40, 8'h40},
            '{8'h40, 8'h40, 8'h00, 14'h0020, 8'h40, 8'h00, 8'h00, 8'h00, 8'h40},
            '{8'h00, 8'h00, 8'h00, 14'h0800, 8'h08, 8'h08, 8'h00, 8'h00, 8'h00},
            '{8'h00, 8'h00, 8'h08, 14'h0c00, 8'h08, 8'h08, 8'h00, 8'h00, 8'h08},
            '{8'h00, 8'h00, 8'h00, 14'h2000, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00},
            '{8'h00, 8'h00, 8'h00, 14'h1000, 8'h30, 8'h30, 8'h00, 8'h00, 8'h30},
            '{8'h00, 8'h00, 8'h81, 14'h0400, 8'h81, 8'h81, 8'h00, 8'h00, 8'h81}};
        arst_n = 1'b0;
        {global_pullup_disable, pin_change_group0_enable, receiver_enable_flag, transmitter_enable_flag} = 4'h0;
        {serial_transmit_line, clock_output_fuse, io_clock, serif_two_wire_mode, serif_three_wire_mode} = 5'h00;
        {serial_clock_hold, serial_clock_toggle_strobe, serif_data_out, start_condition_int_enable} = 4'h0;
        {comparator_neg_digital_disable, comparator_pos_digital_disable, usart_sync_mode} = 3'h0;
        {usart_ext_clock_out, test_port_enable, test_data_out} = 3'h0;
        {pe_port, pe_ddr, pe_pin_change_enable, pf_port, pf_ddr} = 40'h0;
        pg_pin_in = 8'h20;
        ext_val = 16'h0000;
        wait_cyc(4);
        `CHK("pe_oe_n", 8'hff, pe_oe_n);
        `CHK("reset_input_pin", 1'b1, reset_input_pin);
        `CHK("tap_state", PAOF_TLR, tap_state);
        @(posedge clk);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            @(posedge clk);
            pe_port <= rows[i].port;
            pe_ddr <= rows[i].ddr;
            pe_pin_change_enable <= rows[i].pce;
            {comparator_pos_digital_disable, start_condition_int_enable, comparator_neg_digital_disable,
                pin_change_group0_enable, serif_data_out, io_clock, global_pullup_disable, serial_clock_hold,
                serif_three_wire_mode, serif_two_wire_mode, clock_output_fuse, serial_transmit_line,
                transmitter_enable_flag, receiver_enable_flag} <= rows[i].ctl;
            wait_cyc(6);
            `CHK("pe_oe_n", rows[i].oe & rows[i].mask, pe_oe_n & rows[i].mask);
            `CHK("pe_pullup", rows[i].pull & rows[i].mask, pe_pullup & rows[i].mask);
            `CHK("pe_out", rows[i].out & rows[i].mask, pe_out & rows[i].mask);
            `CHK("pe_in_enable", rows[i].ien & rows[i].mask, pe_in_enable & rows[i].mask);
        end
        // Two-wire clock toggle strobe
        @(posedge clk);
        serif_two_wire_mode <= 1'b1;
        serial_clock_toggle_strobe <= 1'b1;
        wait_cyc(3);
        `CHK("pe_toggle4", 1'b1, pe_toggle[4]);
        @(posedge clk);
        serial_clock_toggle_strobe <= 1'b0;
        wait_cyc(3);
        `CHK("pe_toggle4", 1'b0, pe_toggle[4]);
        // Counter clocks and reset pin
        @(posedge clk);
        pg_pin_in <= 8'h10;
        pf_port <= 8'h0a;
        pf_ddr <= 8'h03;
        wait_cyc(6);
        `CHK("counter0_clk", 1'b1, counter0_external_clock);
        `CHK("counter1_clk", 1'b0, counter1_external_clock);
        `CHK("reset_input_pin", 1'b0, reset_input_pin);
        // External clock pin as output, then as pulled-up input
        @(posedge clk);
        usart_sync_mode <= 1'b1;
        usart_ext_clock_out <= 1'b1;
        pe_ddr <= 8'h04;
        wait_cyc(2);
        `CHK("xck_out", 2'b01, {pe_oe_n[2], pe_out[2]});
        @(posedge clk);
        pe_ddr <= 8'h00;
        pe_port <= 8'h04;
        wait_cyc(6);
        `CHK("xck_in", 1'b1, usart_external_clock);
        @(posedge clk);
        usart_sync_mode <= 1'b0;
        wait_cyc(2);
        `CHK("xck_in_off", 1'b0, usart_external_clock);
        @(posedge clk);
        pg_pin_in <= 8'h28;
        test_port_enable <= 1'b1;
        test_data_out <= 1'b1;
        wait_cyc(6);
        `CHK("counter1_clk", 1'b1, counter1_external_clock);
        `CHK("reset_input_pin", 1'b1, reset_input_pin);
        `CHK("pf_out_low", 4'ha, pf_out[3:0]);
        `CHK("pf_oe_n_low", 4'hc, pf_oe_n[3:0]);
        `CHK("converter_en", 4'hf, converter_channel_en);
        `CHK("pf_pullup_hi", 4'hf, pf_pullup[7:4]);
        `CHK("pf_in_en_hi", 4'h1, pf_in_enable[7:4]);
        `CHK("pf_oe_n_hi", 4'hf, pf_oe_n[7:4]);
        `CHK("test_data_in", 1'b1, test_data_in);
        // Walk the test controller into data shift and out again
        tck(1'b0);
        tck(1'b1);
        tck(1'b0);
        tck(1'b0);
        `CHK("test_mode_select", 1'b0, test_mode_select);
        `CHK("tap_state", PAOF_SDR, tap_state);
        `CHK("tdo_oe_n", 1'b0, pf_oe_n[6]);
        `CHK("tdo_out", 1'b1, pf_out[6]);
        tck(1'b1);
        `CHK("test_mode_select", 1'b1, test_mode_select);
        `CHK("tap_state", PAOF_E1D, tap_state);
        `CHK("tdo_oe_n", 1'b1, pf_oe_n[6]);
        `CHK("tdo_pullup", 1'b1, pf_pullup[6]);
        // Second reset with the test port still enabled
        @(posedge clk);
        arst_n <= 1'b0;
        wait_cyc(2);
        `CHK("pf_pullup_rst", 3'b111, {pf_pullup[7], pf_pullup[5:4]});
        `CHK("tap_state", PAOF_TLR, tap_state);
        @(posedge clk);
        arst_n <= 1'b1;
        test_port_enable <= 1'b0;
        wait_cyc(4);
        `CHK("tap_state", PAOF_TLR, tap_state);
        close_out();
    end
endmodule
`undef CHK
`default_nettype wire
